// ### bmd_pkg.sv
package bmd_pkg;
  localparam int ACC_W = 32;
  localparam int HALF_DIGITS = 4;
  localparam int ACC_DIGITS = 8;
  localparam int PROD_DIGITS = 16;
  localparam int DIGIT_W = 4;
  localparam int BIN_W = 27;
  localparam int PBIN_W = 54;
  localparam int STACK_DEPTH = 8;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_ADJ_LIM = 4'h4;
  localparam logic [3:0] BCD_ADJ = 4'h3;
  localparam logic [26:0] TEN = 27'h00A;
  localparam int MANT_W = 23;
  localparam int EXP_LO = 23;
  localparam int SIGN_B = 31;
  localparam logic [7:0] EXP_MAX = 8'hFF;
  localparam logic [7:0] EXP_ZERO = 8'h00;
  localparam logic signed [9:0] EXP_BIAS = 10'sh07F;
  localparam logic signed [9:0] EXP_ONE = 10'sh001;
  localparam logic signed [9:0] EXP_TOP = 10'sh0FF;
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;
  localparam logic [15:0] HALF_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    OP_MUL_SINGLE = 2'b00,
    OP_MUL_DOUBLE = 2'b01,
    OP_MUL_REAL   = 2'b10,
    OP_DIV_SINGLE = 2'b11
  } bmd_op_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CALC = 1'b1
  } bmd_state_t;

  function automatic logic bcdValid(input logic [31:0] v, input int digits);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < ACC_DIGITS; i++)
      if (i < digits && v[i*DIGIT_W +: DIGIT_W] > BCD_MAX)
        ok = 1'b0;
    return ok;
  endfunction : bcdValid

  function automatic logic [26:0] bcdToBin(input logic [31:0] v);
    logic [26:0] r;
    r = '0;
    for (int i = ACC_DIGITS - 1; i >= 0; i--)
      r = 27'(r * TEN) + 27'(v[i*DIGIT_W +: DIGIT_W]);
    return r;
  endfunction : bcdToBin

  function automatic logic [63:0] binToBcd(input logic [53:0] b);
    logic [63:0] d;
    d = '0;
    for (int i = PBIN_W - 1; i >= 0; i--)
    begin
      for (int j = 0; j < PROD_DIGITS; j++)
        if (d[j*DIGIT_W +: DIGIT_W] > BCD_ADJ_LIM)
          d[j*DIGIT_W +: DIGIT_W] = d[j*DIGIT_W +: DIGIT_W] + BCD_ADJ;
      d = {d[62:0], b[i]};
    end
    return d;
  endfunction : binToBcd
endpackage : bmd_pkg

// ### bmd_unit.sv
`timescale 1ns/1ps
module bmd_unit
  import bmd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire bmd_op_t     opcode,
  input  wire logic [31:0] operand,
  input  wire logic        operandIndirect,
  input  wire logic        pointerValid,
  input  wire logic        accLoad,
  input  wire logic [31:0] accLoadValue,
  output logic [31:0]      accumulator,
  output logic [31:0]      stackTop,
  output logic             busy,
  output logic             done,
  output logic             zeroResultFlag,
  output logic             negativeResultFlag,
  output logic             badPointerFlag,
  output logic             invalidRealFlag,
  output logic             signErrorFlag,
  output logic             underflowFlag,
  output logic             badOperandFormatFlag,
  output logic             operandRangeFlag
);

  bmd_state_t  state;
  bmd_state_t  next_state;
  bmd_op_t     opReg;
  bmd_op_t     next_opReg;
  logic [31:0] operandReg;
  logic [31:0] next_operandReg;
  logic        ptrBadReg;
  logic        next_ptrBadReg;
  logic [31:0] next_accumulator;
  logic        next_done;
  logic [31:0] stack [STACK_DEPTH];
  logic [31:0] next_stack [STACK_DEPTH];
  logic        next_zero;
  logic        next_neg;
  logic        next_badPtr;
  logic        next_invReal;
  logic        next_signErr;
  logic        next_under;
  logic        next_badFmt;
  logic        next_range;
  logic        pushEn;
  logic [31:0] pushValue;

  logic [26:0] accBin;
  logic [26:0] accLowBin;
  logic [26:0] opBin;
  logic [26:0] opLowBin;
  logic [53:0] prodBin;
  logic [63:0] prodBcd;
  logic [26:0] quotBin;
  logic [26:0] remBin;
  logic [63:0] quotBcd;
  logic [63:0] remBcd;
  logic [31:0] realRes;
  logic        realUnder;

  // decimal to binary conversions, binary product, quotient and remainder, and conversion back to BCD
  always_comb
  begin
    accBin = bcdToBin(accumulator);
    accLowBin = bcdToBin({HALF_ZERO, accumulator[15:0]});
    opBin = bcdToBin(operandReg);
    opLowBin = bcdToBin({HALF_ZERO, operandReg[15:0]});
    if (opReg == OP_MUL_SINGLE)
      prodBin = 54'(accLowBin) * 54'(opLowBin);
    else
      prodBin = 54'(accBin) * 54'(opBin);
    prodBcd = binToBcd(prodBin);
    quotBin = (opLowBin == '0) ? '0 : accBin / opLowBin;
    remBin = (opLowBin == '0) ? '0 : accBin % opLowBin;
    quotBcd = binToBcd(54'(quotBin));
    remBcd = binToBcd(54'(remBin));
  end

  // single-precision multiply, truncating, denormals flushed
  always_comb
  begin
    logic        sgn;
    logic [47:0] p;
    logic signed [9:0] e;
    logic [22:0] m;
    sgn = accumulator[SIGN_B] ^ operandReg[SIGN_B];
    p = {1'b1, accumulator[MANT_W-1:0]} * {1'b1, operandReg[MANT_W-1:0]};
    e = signed'({2'b00, accumulator[SIGN_B-1:EXP_LO]})
      + signed'({2'b00, operandReg[SIGN_B-1:EXP_LO]}) - EXP_BIAS;
    m = p[45:23];
    realUnder = 1'b0;
    if (p[47])
    begin
      m = p[46:24];
      e = e + EXP_ONE;
    end
    if (accumulator[SIGN_B-1:EXP_LO] == EXP_ZERO || operandReg[SIGN_B-1:EXP_LO] == EXP_ZERO)
      realRes = {sgn, 31'h0000_0000};
    else if (e <= 0)
    begin
      realRes = {sgn, 31'h0000_0000};
      realUnder = 1'b1;
    end
    else if (e >= EXP_TOP)
      realRes = {sgn, EXP_MAX, 23'h00_0000};
    else
      realRes = {sgn, e[7:0], m};
  end

  // sequencing, accumulator, flags and stack
  always_comb
  begin
    logic [31:0] res;
    logic        bad;
    res = accumulator;
    bad = 1'b0;
    next_state = state;
    next_opReg = opReg;
    next_operandReg = operandReg;
    next_ptrBadReg = ptrBadReg;
    next_accumulator = accumulator;
    next_done = 1'b0;
    next_zero = zeroResultFlag;
    next_neg = negativeResultFlag;
    next_badPtr = badPointerFlag;
    next_invReal = invalidRealFlag;
    next_signErr = signErrorFlag;
    next_under = underflowFlag;
    next_badFmt = badOperandFormatFlag;
    next_range = operandRangeFlag;
    pushEn = 1'b0;
    pushValue = ACC_RESET;
    unique case (state)
      ST_IDLE:
      begin
        if (start)
        begin
          next_state = ST_CALC;
          next_opReg = opcode;
          next_operandReg = operand;
          next_ptrBadReg = operandIndirect && !pointerValid;
        end
        else if (accLoad)
          next_accumulator = accLoadValue;
      end
      ST_CALC:
      begin
        next_state = ST_IDLE;
        next_done = 1'b1;
        next_badPtr = ptrBadReg;
        unique case (opReg)
          OP_MUL_SINGLE:
          begin
            bad = !bcdValid(accumulator, HALF_DIGITS) || !bcdValid(operandReg, HALF_DIGITS);
            if (!bad && !ptrBadReg)
              res = prodBcd[31:0];
          end
          OP_MUL_DOUBLE:
          begin
            bad = !bcdValid(accumulator, ACC_DIGITS) || !bcdValid(operandReg, ACC_DIGITS);
            if (!bad && !ptrBadReg)
            begin
              res = prodBcd[31:0];
              pushEn = 1'b1;
              pushValue = prodBcd[63:32];
            end
          end
          OP_MUL_REAL:
          begin
            bad = accumulator[SIGN_B-1:EXP_LO] == EXP_MAX
              || operandReg[SIGN_B-1:EXP_LO] == EXP_MAX;
            next_signErr = 1'b0;
            next_under = !bad && !ptrBadReg && realUnder;
            if (!bad && !ptrBadReg)
              res = realRes;
            next_invReal = res[SIGN_B-1:EXP_LO] == EXP_MAX;
          end
          OP_DIV_SINGLE:
          begin
            bad = !bcdValid(accumulator, ACC_DIGITS) || !bcdValid(operandReg, HALF_DIGITS);
            next_range = !bad && opLowBin == '0;
            if (!bad && !ptrBadReg && opLowBin != '0)
            begin
              res = quotBcd[31:0];
              pushEn = 1'b1;
              pushValue = remBcd[31:0];
            end
          end
        endcase
        next_badFmt = bad;
        next_accumulator = res;
        next_zero = res == ACC_RESET;
        next_neg = res[SIGN_B];
      end
    endcase
    for (int i = 0; i < STACK_DEPTH; i++)
      next_stack[i] = stack[i];
    if (pushEn)
    begin
      for (int i = 1; i < STACK_DEPTH; i++)
        next_stack[i] = stack[i-1];
      next_stack[0] = pushValue;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      opReg <= OP_MUL_SINGLE;
      operandReg <= ACC_RESET;
      ptrBadReg <= 1'b0;
      accumulator <= ACC_RESET;
      done <= 1'b0;
      zeroResultFlag <= 1'b0;
      negativeResultFlag <= 1'b0;
      badPointerFlag <= 1'b0;
      invalidRealFlag <= 1'b0;
      signErrorFlag <= 1'b0;
      underflowFlag <= 1'b0;
      badOperandFormatFlag <= 1'b0;
      operandRangeFlag <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack[i] <= ACC_RESET;
    end
    else
    begin
      state <= next_state;
      opReg <= next_opReg;
      operandReg <= next_operandReg;
      ptrBadReg <= next_ptrBadReg;
      accumulator <= next_accumulator;
      done <= next_done;
      zeroResultFlag <= next_zero;
      negativeResultFlag <= next_neg;
      badPointerFlag <= next_badPtr;
      invalidRealFlag <= next_invReal;
      signErrorFlag <= next_signErr;
      underflowFlag <= next_under;
      badOperandFormatFlag <= next_badFmt;
      operandRangeFlag <= next_range;
      for (int i = 0; i < STACK_DEPTH; i++)
        stack[i] <= next_stack[i];
    end
  end

  assign busy = state == ST_CALC;
  assign stackTop = stack[0];

  // checks
  logic accepted;
  assign accepted = start && !busy;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_zero;
    done |-> zeroResultFlag == (accumulator == ACC_RESET);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_neg;
    done |-> negativeResultFlag == accumulator[SIGN_B];
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");

  property p_flagHold;
    !done && !$past(rst) |-> $stable({zeroResultFlag, negativeResultFlag, badPointerFlag, invalidRealFlag,
      signErrorFlag, underflowFlag, badOperandFormatFlag, operandRangeFlag});
  endproperty
  a_flagHold: assert property (p_flagHold) else $error("flag changed without instruction");

  property p_mulZero;
    accepted && opcode == OP_MUL_SINGLE && operand == ACC_RESET && !operandIndirect
      && bcdValid(accumulator, HALF_DIGITS) |-> ##2 done && accumulator == ACC_RESET && zeroResultFlag;
  endproperty
  a_mulZero: assert property (p_mulZero) else $error("single multiply by zero not zero");

  property p_badBcd;
    accepted && opcode == OP_MUL_SINGLE && !bcdValid(operand, HALF_DIGITS)
      |-> ##2 badOperandFormatFlag && accumulator == $past(accumulator, 2);
  endproperty
  a_badBcd: assert property (p_badBcd) else $error("non-BCD operand not flagged");

  property p_badPtr;
    accepted && operandIndirect && !pointerValid |-> ##2 badPointerFlag && done;
  endproperty
  a_badPtr: assert property (p_badPtr) else $error("bad pointer not flagged");

  property p_divZero;
    accepted && opcode == OP_DIV_SINGLE && operand[15:0] == HALF_ZERO
      && bcdValid(accumulator, ACC_DIGITS) |-> ##2 operandRangeFlag && $stable(stackTop);
  endproperty
  a_divZero: assert property (p_divZero) else $error("zero divisor not flagged");

  property p_push;
    busy && pushEn |=> stack[1] == $past(stack[0]) && stackTop == $past(pushValue);
  endproperty
  a_push: assert property (p_push) else $error("stack push wrong");

  property p_mulDoubleZero;
    accepted && opcode == OP_MUL_DOUBLE && operand == ACC_RESET && !operandIndirect
      && bcdValid(accumulator, ACC_DIGITS) |-> ##2 accumulator == ACC_RESET && stackTop == ACC_RESET;
  endproperty
  a_mulDoubleZero: assert property (p_mulDoubleZero) else $error("double multiply zero wrong");

  c_mulDouble: cover property (done && opReg == OP_MUL_DOUBLE && !badOperandFormatFlag);
  c_real: cover property (done && opReg == OP_MUL_REAL && underflowFlag);
  c_div: cover property (done && opReg == OP_DIV_SINGLE && stackTop != ACC_RESET);
endmodule : bmd_unit

// ### bmd_seq_model.sv
`timescale 1ns/1ps
// sequencer and data memory side, presents one instruction per request
module bmd_seq_model
  import bmd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        busy,
  input  wire logic        issue,
  input  wire bmd_op_t     issueOp,
  input  wire logic [15:0] issueHi,
  input  wire logic [15:0] issueLo,
  input  wire logic        issueInd,
  input  wire logic        issuePtrOk,
  output logic             start,
  output bmd_op_t          opcode,
  output logic [31:0]      operand,
  output logic             operandIndirect,
  output logic             pointerValid
);
  logic        next_start;
  logic [31:0] next_operand;
  always_comb
  begin
    next_start   = issue && !busy && !start;
    // second memory word in the high half, scrambled when idle
    next_operand = next_start ? {issueHi, issueLo} : ~operand;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      start           <= 1'b0;
      opcode          <= OP_MUL_SINGLE;
      operand         <= 32'h0000_0000;
      operandIndirect <= 1'b0;
      pointerValid    <= 1'b1;
    end
    else
    begin
      // qualifiers only mean something with start, scrambled otherwise
      start           <= next_start;
      opcode          <= next_start ? issueOp : bmd_op_t'(~opcode);
      operand         <= next_operand;
      operandIndirect <= next_start ? issueInd : !operandIndirect;
      pointerValid    <= next_start ? issuePtrOk : !pointerValid;
    end
  end
endmodule : bmd_seq_model

// ### tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    checks_done++; \
    if ((gt) !== (ex)) \
    begin \
      $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
      err_total++; \
    end \
  end
module tb_top
  import bmd_pkg::*;
;
  typedef struct packed {
    bmd_op_t op;
    logic [31:0] acc, opnd, expAcc, expStk;
    logic [7:0] expFlg;
  } bmd_row_t;
  logic mclk = 0, rst = 1, issue = 0, issueInd = 0, issuePtrOk = 1, accLoad = 0;
  logic [31:0] accLoadValue = '0, issueWord = '0, accumulator, stackTop, operand;
  bmd_op_t issueOp = OP_MUL_SINGLE, opcode;
  logic start, busy, done, operandIndirect, pointerValid;
  logic zf, nf, pf, rf, sf, uf, bf, of;
  logic [7:0] flg;
  int err_total = 0, checks_done = 0, cyc = 0;
  assign flg = {zf, nf, pf, rf, sf, uf, bf, of};
  bmd_row_t rows[14] = '{
    '{OP_MUL_SINGLE, 32'h0000_1234, 32'h0000_5678, 32'h0700_6652, 32'h0, 8'h00},
    '{OP_MUL_SINGLE, 32'h9999_0002, 32'h0000_9999, 32'h0001_9998, 32'h0, 8'h00},
    '{OP_MUL_SINGLE, 32'h0000_1234, 32'h0000_0000, 32'h0000_0000, 32'h0, 8'h80},
    '{OP_MUL_DOUBLE, 32'h9999_9999, 32'h0000_0002, 32'h9999_9998, 32'h1, 8'h40},
    '{OP_MUL_DOUBLE, 32'h1234_5678, 32'h0001_0000, 32'h5678_0000, 32'h1234, 8'h00},
    '{OP_MUL_SINGLE, 32'h0000_0042, 32'h0000_00A0, 32'h0000_0042, 32'h1234, 8'h02},
    '{OP_MUL_DOUBLE, 32'h1234_5678, 32'h0000_0000, 32'h0000_0000, 32'h0, 8'h80},
    '{OP_DIV_SINGLE, 32'h0000_0100, 32'h0000_0007, 32'h0000_0014, 32'h2, 8'h00},
    '{OP_DIV_SINGLE, 32'h1234_5678, 32'h0000_9999, 32'h0000_1234, 32'h6912, 8'h00},
    '{OP_DIV_SINGLE, 32'h0000_00A0, 32'h0000_0001, 32'h0000_00A0, 32'h6912, 8'h02},
    '{OP_MUL_REAL, 32'h4000_0000, 32'h4040_0000, 32'h40C0_0000, 32'h6912, 8'h00},
    '{OP_MUL_REAL, 32'h0080_0000, 32'h3F00_0000, 32'h0000_0000, 32'h6912, 8'h84},
    '{OP_MUL_REAL, 32'h7F00_0000, 32'h4000_0000, 32'h7F80_0000, 32'h6912, 8'h10},
    '{OP_MUL_REAL, 32'h4000_0000, 32'h7F80_0000, 32'h4000_0000, 32'h6912, 8'h02}};
  bmd_seq_model i_bmd_seq_model (.mclk(mclk), .rst(rst), .busy(busy), .issue(issue),
    .issueOp(issueOp), .issueHi(issueWord[31:16]), .issueLo(issueWord[15:0]),
    .issueInd(issueInd), .issuePtrOk(issuePtrOk), .start(start), .opcode(opcode),
    .operand(operand), .operandIndirect(operandIndirect), .pointerValid(pointerValid));
  bmd_unit i_bmd_unit (.mclk(mclk), .rst(rst), .start(start), .opcode(opcode),
    .operand(operand), .operandIndirect(operandIndirect), .pointerValid(pointerValid),
    .accLoad(accLoad), .accLoadValue(accLoadValue), .accumulator(accumulator),
    .stackTop(stackTop), .busy(busy), .done(done), .zeroResultFlag(zf),
    .negativeResultFlag(nf), .badPointerFlag(pf), .invalidRealFlag(rf),
    .signErrorFlag(sf), .underflowFlag(uf), .badOperandFormatFlag(bf), .operandRangeFlag(of));
  always #2.5 mclk = ~mclk;
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic loadAcc(input logic [31:0] v);
    accLoadValue = v;
    accLoad = 1;
    @(posedge mclk);
    #1 accLoad = 0;
  endtask : loadAcc
  task automatic runOp(input bmd_op_t op, input logic [31:0] w, input logic ind, input logic ok);
    int n;
    issueOp = op;
    issueWord = w;
    issueInd = ind;
    issuePtrOk = ok;
    issue = 1;
    @(posedge mclk);
    #1 issue = 0;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1 n++;
    end
    while (done !== 1'b1 && n < 10);
    `CHK("latency", 2, n)
  endtask : runOp
  task automatic check(input string nm, input logic [31:0] a, s, input logic [7:0] f);
    `CHK("accumulator", a, accumulator)
    `CHK("stackTop", s, stackTop)
    `CHK("flags", f, flg)
    $display("test %s done", nm);
  endtask : check
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      conclude();
    end
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    #1 rst = 0;
    `CHK("idle", 2'b00, {busy, done})
    check("reset", 32'h0, 32'h0, 8'h00);
    foreach (rows[i])
    begin
      loadAcc(rows[i].acc);
      runOp(rows[i].op, rows[i].opnd, 1'b0, 1'b1);
      check("row", rows[i].expAcc, rows[i].expStk, rows[i].expFlg);
    end
    loadAcc(32'h0000_0050);
    runOp(OP_DIV_SINGLE, 32'h0, 1'b0, 1'b1);
    check("zero divisor", 32'h0000_0050, 32'h6912, 8'h01);
    runOp(OP_MUL_SINGLE, 32'h0000_0002, 1'b0, 1'b1);
    check("range held", 32'h0000_0100, 32'h6912, 8'h01);
    runOp(OP_DIV_SINGLE, 32'h0000_0004, 1'b0, 1'b1);
    check("range cleared", 32'h0000_0025, 32'h0, 8'h00);
    loadAcc(32'h0000_0001);
    runOp(OP_MUL_SINGLE, 32'h0000_0003, 1'b1, 1'b0);
    check("bad pointer", 32'h0000_0001, 32'h0, 8'h20);
    runOp(OP_MUL_REAL, 32'h4000_0000, 1'b1, 1'b0);
    check("bad pointer real", 32'h0000_0001, 32'h0, 8'h20);
    rst = 1;
    @(posedge mclk);
    #1 rst = 0;
    check("second reset", 32'h0, 32'h0, 8'h00);
    conclude();
  end
endmodule : tb_top
